// ---- inc/ddr3_mode_pkg.sv ----
package ddr3_mode_pkg;

	// Pin widths
	localparam int ADDR_W = 16;
	localparam int BA_W = 3;
	localparam int DQ_W = 16;
	localparam int LANE_W = 8;

	// Mode register select on the bank pins during a mode register set
	localparam logic [2:0] MR0_SEL = 3'h0;
	localparam logic [2:0] MR1_SEL = 3'h1;
	localparam logic [2:0] MR2_SEL = 3'h2;
	localparam logic [2:0] MR3_SEL = 3'h3;

	// Field positions inside the mode registers
	localparam int MR0_BL_LSB = 0;
	localparam int MR0_CL_LSB = 4;
	localparam int MR1_DLL_OFF_BIT = 0;
	localparam int MR1_AL_LSB = 3;
	localparam int MR2_CWL_LSB = 3;
	localparam int MR3_LOC_LSB = 0;
	localparam int MR3_MPR_BIT = 2;

	// Column address bits that steer a read or write
	localparam int COL_NIBBLE_BIT = 2;
	localparam int COL_AP_BIT = 10;
	localparam int COL_BC_BIT = 12;
	localparam int COL_W = 10;

	// Reset values of the mode register fields
	localparam logic [1:0] BL_RST = 2'h0;
	localparam logic [2:0] CL_FIELD_RST = 3'h2;
	localparam logic [1:0] AL_FIELD_RST = 2'h0;
	localparam logic [2:0] CWL_FIELD_RST = 3'h1;
	localparam logic [1:0] LOC_RST = 2'h0;

	// Burst length field encodings
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;

	// Readout location holding the calibration pattern; bit n goes out on beat n
	localparam logic [1:0] LOC_CALIB = 2'h0;
	localparam logic [7:0] CALIB_PATTERN = 8'hAA;

	// Latency bases and the one pair allowed with the DLL off
	localparam logic [4:0] CL_BASE = 5'h04;
	localparam logic [4:0] CWL_BASE = 5'h05;
	localparam logic [4:0] CL_DLL_OFF = 5'h06;
	localparam logic [4:0] CWL_DLL_OFF = 5'h06;

	// Beats per burst
	localparam logic [3:0] BEATS_BL8 = 4'h8;
	localparam logic [3:0] BEATS_BC4 = 4'h4;

	// Read latency pipe: the data path adds two stages after the tap
	localparam int PIPE_DEPTH = 32;
	localparam logic [4:0] PIPE_OFFSET = 5'h02;

	// Decoded command
	typedef enum logic [3:0] {
		CMD_DESEL = 4'h0,
		CMD_NOP = 4'h1,
		CMD_MRS = 4'h2,
		CMD_REF = 4'h3,
		CMD_PRE = 4'h4,
		CMD_ACT = 4'h5,
		CMD_WR = 4'h6,
		CMD_RD = 4'h7,
		CMD_ZQ = 4'h8
	} cmd_e;

	// Device mode: one bit changes on each step away from run
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_MPR = 2'b01,
		ST_SREF = 2'b10
	} dev_state_e;

	// Read latency in clocks: additive plus read latency, one less with the DLL off
	function automatic logic [4:0] read_latency(input logic [2:0] cl_f, input logic [1:0] al_f,
		input logic dll_off);
		logic [4:0] cl;
		logic [4:0] al;
		cl = CL_BASE + {2'b00, cl_f};
		case (al_f)
			2'h1: al = cl - 5'h01;
			2'h2: al = cl - 5'h02;
			default: al = 5'h00;
		endcase
		read_latency = cl + al - {4'h0, dll_off};
	endfunction

endpackage

// ---- hw/read_latency_pipe.sv ----
`timescale 1ns/100ps
// Delay line that carries each read's burst description to its launch cycle
module read_latency_pipe import ddr3_mode_pkg::*; #(
	parameter int DEPTH = PIPE_DEPTH,
	parameter int W = 4
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic push_in,
	input wire logic [W-1:0] info_in,
	input wire logic [4:0] tap_in,
	output logic pop_out,
	output logic [W-1:0] info_out
);

	logic [DEPTH-1:0] valid_q; // One flag per cycle of delay
	logic [W-1:0] info_q [DEPTH]; // Burst description travelling with each flag

	// Shift every cycle; a read never waits, so no stall path is needed
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			valid_q <= '0;
		end else begin
			valid_q <= {valid_q[DEPTH-2:0], push_in};
		end
	end

	// Payload needs no reset, the flag qualifies it
	always_ff @(posedge ref_clk_in) begin
		info_q[0] <= info_in;
		for (int i = 1; i < DEPTH; i++) begin
			info_q[i] <= info_q[i-1];
		end
	end

	// Tap picked by the programmed latency
	assign pop_out = valid_q[tap_in];
	assign info_out = info_q[tap_in];

endmodule

// ---- hw/burst_beat_gen.sv ----
`timescale 1ns/100ps
// Steps through the beats of one read burst in the documented order
module burst_beat_gen import ddr3_mode_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic [2:0] start_pos_in,
	input wire logic chop_in,
	input wire logic mpr_in,
	output logic active_out,
	output logic [2:0] pos_out,
	output logic mpr_out
);

	logic [3:0] left_q; // Beats still to go after the current one

	// A new start restarts the burst, which also covers a seamless follow-on read
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			active_out <= 1'b0;
			pos_out <= 3'h0;
			mpr_out <= 1'b0;
			left_q <= 4'h0;
		end else if (start_in) begin
			active_out <= 1'b1;
			pos_out <= start_pos_in;
			mpr_out <= mpr_in;
			left_q <= (chop_in ? BEATS_BC4 : BEATS_BL8) - 4'h1;
		end else if (active_out) begin
			if (left_q == 4'h0) begin
				active_out <= 1'b0;
			end else begin
				pos_out <= pos_out + 3'h1;
				left_q <= left_q - 4'h1;
			end
		end
	end

endmodule

// ---- hw/ddr3_mode_ctrl.sv ----
`timescale 1ns/100ps
// Operation
// - MR3 bit two set enters readout mode
// - Readout mode serves reads from the register
// - Read with auto precharge acts as read
// - Readout bit clear means normal array access
// - Lane bit zero carries bit, others copy/zero
// - Column low bits zero; other address ignored
// - Burst order by nibble bit and chop
// - Burst chop honoured, fixed or per command
// - DLL locked first; normal read latency applies
// - Beat zero is LSB, beat seven MSB
// - Location zero returns alternating calibration pattern
// - No-operation registers nothing, disturbs nothing
// - Deselect executes nothing; bursts continue
// - MR1 bit zero disables the DLL
// - DLL off supports only latency six/six
// - DLL off launches read one cycle early
module ddr3_mode_ctrl import ddr3_mode_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic cke_in,
	input wire logic cs_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic [BA_W-1:0] ba_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic lane_copy_in,
	input wire logic [DQ_W-1:0] array_rdata_in,
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe_out,
	output logic [2:0] beat_pos_out,
	output logic array_rd_out,
	output logic array_wr_out,
	output logic auto_precharge_out,
	output logic [BA_W-1:0] array_bank_out,
	output logic [COL_W-1:0] array_col_out,
	output logic mpr_mode_out,
	output logic self_refresh_out,
	output logic dll_off_out,
	output logic latency_error_out,
	output logic illegal_cmd_out
);

	cmd_e cmd; // Command seen this cycle
	dev_state_e state_q; // Run, readout mode or self refresh
	logic [1:0] bl_q; // Burst length field
	logic [2:0] cl_q; // Read latency field
	logic [1:0] al_q; // Additive latency field
	logic [2:0] cwl_q; // Write latency field
	logic [1:0] loc_q; // Readout location select
	logic dll_off_q; // DLL bypass flag
	logic is_rd; // Read or read with auto precharge
	logic mpr_rd; // Read served by the readout register
	logic chop; // This read is a four-beat chop
	logic [2:0] start_pos; // First beat position
	logic [4:0] rl; // Current read latency
	logic [4:0] tap; // Pipe tap for that latency
	logic launch; // Burst starts in the beat generator
	logic [4:0] launch_info; // {mpr, chop, start position}
	logic [4:0] u_info; // Description of the launching burst
	logic beat_active; // Beat generator is in a burst
	logic [2:0] beat_pos; // Burst position of this beat
	logic beat_mpr; // Beat belongs to a readout register read
	logic calib_bit; // Register bit for this beat
	logic [4:0] cl_eff; // Programmed read latency
	logic [4:0] cwl_eff; // Programmed write latency

	// Command decode; deselect and no-operation fall through and touch nothing
	always_comb begin
		if (cs_n_in || !cke_in && !(state_q != ST_SREF && !ras_n_in && !cas_n_in && we_n_in)) begin
			cmd = CMD_DESEL;
		end else begin
			case ({ras_n_in, cas_n_in, we_n_in})
				3'b000: cmd = CMD_MRS;
				3'b001: cmd = CMD_REF;
				3'b010: cmd = CMD_PRE;
				3'b011: cmd = CMD_ACT;
				3'b100: cmd = CMD_WR;
				3'b101: cmd = CMD_RD;
				3'b110: cmd = CMD_ZQ;
				default: cmd = CMD_NOP;
			endcase
		end
	end

	// Read steering: readout mode redirects, auto precharge is dropped there
	assign is_rd = (cmd == CMD_RD) && cke_in;
	assign mpr_rd = is_rd && (state_q == ST_MPR);
	// Chop is fixed by mode or picked per command when on-the-fly is set
	assign chop = (bl_q == BL_FIXED4) || (bl_q == BL_OTF && !addr_in[COL_BC_BIT]);
	// Nibble bit picks the half only for a chop; low column bits are ignored
	assign start_pos = chop ? {addr_in[COL_NIBBLE_BIT], 2'b00} : 3'h0;
	assign launch_info = {mpr_rd, chop, start_pos};

	// Latency with the one-cycle shift of bypass mode
	assign rl = read_latency(cl_q, al_q, dll_off_q);
	assign tap = rl - PIPE_OFFSET;
	assign cl_eff = CL_BASE + {2'b00, cl_q};
	assign cwl_eff = CWL_BASE + {2'b00, cwl_q};

	// Mode register fields; in readout mode every register still changes, and MR3 can leave it
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bl_q <= BL_RST;
			cl_q <= CL_FIELD_RST;
			al_q <= AL_FIELD_RST;
			cwl_q <= CWL_FIELD_RST;
			loc_q <= LOC_RST;
			dll_off_q <= 1'b0;
		end else if (cmd == CMD_MRS && state_q != ST_SREF) begin
			case (ba_in)
				MR0_SEL: begin
					bl_q <= addr_in[MR0_BL_LSB +: 2];
					cl_q <= addr_in[MR0_CL_LSB +: 3];
				end
				MR1_SEL: begin
					dll_off_q <= addr_in[MR1_DLL_OFF_BIT];
					al_q <= addr_in[MR1_AL_LSB +: 2];
				end
				MR2_SEL: begin
					cwl_q <= addr_in[MR2_CWL_LSB +: 3];
				end
				MR3_SEL: begin
					loc_q <= addr_in[MR3_LOC_LSB +: 2];
				end
				default: begin
				end
			endcase
		end
	end

	// Device mode; self refresh entry is refused while readout mode is on
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ST_RUN;
		end else begin
			case (state_q)
				ST_RUN: begin
					if (cmd == CMD_MRS && ba_in == MR3_SEL && addr_in[MR3_MPR_BIT]) begin
						state_q <= ST_MPR;
					end else if (cmd == CMD_REF && !cke_in) begin
						state_q <= ST_SREF;
					end
				end
				ST_MPR: begin
					if (cmd == CMD_MRS && ba_in == MR3_SEL && !addr_in[MR3_MPR_BIT]) begin
						state_q <= ST_RUN;
					end
				end
				ST_SREF: begin
					// Exit on CKE high; controller then holds it high meanwhile
					if (cke_in) begin
						state_q <= ST_RUN;
					end
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end

	// Array requests; none leave the block in readout mode
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			array_rd_out <= 1'b0;
			array_wr_out <= 1'b0;
			auto_precharge_out <= 1'b0;
			array_bank_out <= '0;
			array_col_out <= '0;
		end else begin
			array_rd_out <= is_rd && state_q == ST_RUN;
			array_wr_out <= cmd == CMD_WR && state_q == ST_RUN;
			// Auto precharge only outside readout mode
			auto_precharge_out <= (is_rd || cmd == CMD_WR) && state_q == ST_RUN
				&& addr_in[COL_AP_BIT];
			if (is_rd || cmd == CMD_WR) begin
				array_bank_out <= ba_in;
				array_col_out <= addr_in[COL_W-1:0];
			end
		end
	end

	// Anything but a read, mode set, no-operation or deselect in readout mode, or CKE low there, is flagged and dropped
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			illegal_cmd_out <= 1'b0;
		end else begin
			illegal_cmd_out <= state_q == ST_MPR && (!cke_in || (cmd != CMD_DESEL
				&& cmd != CMD_NOP && cmd != CMD_RD && cmd != CMD_MRS));
		end
	end

	// Bypass mode only works at the one latency pair; warn software otherwise
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			latency_error_out <= 1'b0;
			dll_off_out <= 1'b0;
			mpr_mode_out <= 1'b0;
			self_refresh_out <= 1'b0;
		end else begin
			latency_error_out <= dll_off_q && (cl_eff != CL_DLL_OFF
				|| cwl_eff != CWL_DLL_OFF);
			dll_off_out <= dll_off_q;
			mpr_mode_out <= state_q == ST_MPR;
			self_refresh_out <= state_q == ST_SREF;
		end
	end

	// Delay each read to its launch cycle
	read_latency_pipe #(
		.DEPTH(PIPE_DEPTH),
		.W(5)
	) u_pipe (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.push_in(is_rd),
		.info_in(launch_info),
		.tap_in(tap),
		.pop_out(launch),
		.info_out(u_info)
	);

	// Beat order within the burst
	burst_beat_gen u_beats (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.start_in(launch),
		.start_pos_in(u_info[2:0]),
		.chop_in(u_info[3]),
		.mpr_in(u_info[4]),
		.active_out(beat_active),
		.pos_out(beat_pos),
		.mpr_out(beat_mpr)
	);

	// Reserved locations read as zero; position n takes pattern bit n
	assign calib_bit = (loc_q == LOC_CALIB) ? CALIB_PATTERN[beat_pos] : 1'b0;

	// Data pins; lane bit zero of both bytes carries the register bit
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			dq_out <= '0;
			dq_oe_out <= 1'b0;
			beat_pos_out <= 3'h0;
		end else begin
			dq_oe_out <= beat_active;
			beat_pos_out <= beat_pos;
			if (!beat_active) begin
				dq_out <= '0;
			end else if (beat_mpr) begin
				// Copy or zero on upper lane bits, chosen by a strap port
				dq_out <= {2{lane_copy_in ? {LANE_W{calib_bit}}
					: {{(LANE_W-1){1'b0}}, calib_bit}}};
			end else begin
				dq_out <= array_rdata_in;
			end
		end
	end

	// Assertions
	property p_mpr_enter;
		@(posedge ref_clk_in) disable iff (rst_in)
		(state_q == ST_RUN && cmd == CMD_MRS && ba_in == MR3_SEL && addr_in[MR3_MPR_BIT])
		|=> ##1 mpr_mode_out;
	endproperty
	a_mpr_enter: assert property (p_mpr_enter) else $error("readout mode not entered");

	property p_mpr_no_array;
		@(posedge ref_clk_in) disable iff (rst_in)
		mpr_rd |=> !array_rd_out && !auto_precharge_out;
	endproperty
	a_mpr_no_array: assert property (p_mpr_no_array) else $error("readout read hit array");

	property p_rda_plain;
		@(posedge ref_clk_in) disable iff (rst_in)
		state_q == ST_MPR |=> !auto_precharge_out;
	endproperty
	a_rda_plain: assert property (p_rda_plain) else $error("auto precharge in readout");

	property p_normal_rd;
		@(posedge ref_clk_in) disable iff (rst_in)
		is_rd && state_q == ST_RUN |=> array_rd_out && array_col_out == $past(addr_in[COL_W-1:0]);
	endproperty
	a_normal_rd: assert property (p_normal_rd) else $error("array read lost");

	property p_lane_zero;
		@(posedge ref_clk_in) disable iff (rst_in)
		beat_active && beat_mpr |=> dq_oe_out && dq_out[0] == dq_out[LANE_W]
			&& dq_out[0] == (loc_q == LOC_CALIB && $past(beat_pos[0]));
	endproperty
	a_lane_zero: assert property (p_lane_zero) else $error("calibration bit wrong");

	property p_bc4_len;
		@(posedge ref_clk_in) disable iff (rst_in)
		launch && u_info[3] ##1 !launch [*4] |-> $past(beat_active, 3) && $past(beat_active, 2)
			&& $past(beat_active) && beat_active ##1 !beat_active;
	endproperty
	a_bc4_len: assert property (p_bc4_len) else $error("chop burst length wrong");

	property p_upper_nibble;
		@(posedge ref_clk_in) disable iff (rst_in)
		launch && u_info[3] && u_info[2:0] == 3'h4 |=> beat_pos == 3'h4 ##1 beat_pos == 3'h5;
	endproperty
	a_upper_nibble: assert property (p_upper_nibble) else $error("nibble order wrong");

	property p_nop_quiet;
		@(posedge ref_clk_in) disable iff (rst_in)
		(cmd == CMD_NOP || cmd == CMD_DESEL) && state_q == ST_RUN
		|=> !array_rd_out && !array_wr_out && $stable(state_q);
	endproperty
	a_nop_quiet: assert property (p_nop_quiet) else $error("idle command acted");

	property p_dll_latency;
		@(posedge ref_clk_in) disable iff (rst_in)
		dll_off_q && al_q == 2'h0 && cl_q == 3'h2 && is_rd && !dq_oe_out |-> ##6 dq_oe_out;
	endproperty
	a_dll_latency: assert property (p_dll_latency) else $error("bypass latency wrong");

	property p_lat_err;
		@(posedge ref_clk_in) disable iff (rst_in)
		dll_off_q && cl_eff != CL_DLL_OFF |=> latency_error_out;
	endproperty
	a_lat_err: assert property (p_lat_err) else $error("latency error missed");

	c_mpr_read: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		mpr_rd ##[4:31] dq_oe_out);
	c_bc4_upper: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		launch && u_info[2:0] == 3'h4);
	c_sref: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		self_refresh_out ##1 !self_refresh_out);

endmodule

// ---- test/mem_ctrl_model.sv ----
`timescale 1ns/100ps
// Memory controller stand-in: changes command pins only just after a rising edge
module mem_ctrl_model import ddr3_mode_pkg::*; #(
	parameter int MOD_WAIT = 12, // Settle time after every mode register set
	parameter int PRE_WAIT = 6, // Precharge recovery before a mode change
	parameter int SRE_WAIT = 8, // Clock kept steady after self refresh entry
	parameter int XS_WAIT = 10 // Exit to first command
) (
	input wire logic ref_clk_in,
	output logic cke_out,
	output logic cs_n_out,
	output logic ras_n_out,
	output logic cas_n_out,
	output logic we_n_out,
	output logic [BA_W-1:0] ba_out,
	output logic [ADDR_W-1:0] addr_out
);
	// Deselected and clock enabled from time zero
	initial begin
		cke_out = 1'b1;
		cs_n_out = 1'b1;
		{ras_n_out, cas_n_out, we_n_out} = 3'h7;
		ba_out = '0;
		addr_out = '0;
	end

	// One command; between commands the pins wander so stale values never look valid
	task automatic send(input logic cs_n, input logic [2:0] rcw, input logic [BA_W-1:0] ba,
		input logic [ADDR_W-1:0] a);
		@(posedge ref_clk_in);
		cs_n_out <= cs_n;
		{ras_n_out, cas_n_out, we_n_out} <= rcw;
		ba_out <= ba;
		addr_out <= a;
		@(posedge ref_clk_in);
		cs_n_out <= 1'b1;
		{ras_n_out, cas_n_out, we_n_out} <= ~rcw;
		ba_out <= ~ba;
		addr_out <= ~a;
	endtask

	// Mode register set, then no command until the update delay ran out
	task automatic mrs(input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] a);
		send(1'b0, 3'h0, ba, a);
		repeat (MOD_WAIT) @(posedge ref_clk_in);
	endtask

	// Precharge all banks and let recovery pass before any mode change
	task automatic idle_all();
		send(1'b0, 3'h2, 3'h0, 16'h0400);
		repeat (PRE_WAIT) @(posedge ref_clk_in);
	endtask

	// DLL off, then self refresh entry with clock enable low
	task automatic dll_off_enter();
		idle_all();
		mrs(MR1_SEL, 16'h0001);
		@(posedge ref_clk_in);
		cs_n_out <= 1'b0;
		{ras_n_out, cas_n_out, we_n_out} <= 3'h1;
		cke_out <= 1'b0;
		@(posedge ref_clk_in);
		cs_n_out <= 1'b1;
		{ras_n_out, cas_n_out, we_n_out} <= 3'h6;
		repeat (SRE_WAIT) @(posedge ref_clk_in);
	endtask

	// Exit with clock enable held high from here on, then reprogram latencies six/six
	task automatic sr_exit();
		@(posedge ref_clk_in);
		cke_out <= 1'b1;
		repeat (XS_WAIT) @(posedge ref_clk_in);
		mrs(MR0_SEL, 16'h0021);
		mrs(MR2_SEL, 16'h0008);
	endtask
endmodule

// ---- test/ddr3_mode_ctrl_bench.sv ----
`timescale 1ns/100ps
// Self-checking bench: the controller model issues commands, tasks check the answers
module ddr3_mode_ctrl_bench import ddr3_mode_pkg::*;;
	logic ref_clk; // Clock; kept well inside the bypass period limit
	logic rst;
	logic lane_copy; // Upper lane behaviour select
	logic [DQ_W-1:0] array_rdata = '0; // Array data, changing every cycle
	wire logic cke, cs_n, ras_n, cas_n, we_n;
	wire logic [BA_W-1:0] ba;
	wire logic [ADDR_W-1:0] addr;
	logic [DQ_W-1:0] dq_out;
	logic dq_oe_out, array_rd_out, array_wr_out, auto_precharge_out;
	logic mpr_mode_out, self_refresh_out, dll_off_out, latency_error_out, illegal_cmd_out;
	logic [2:0] beat_pos_out;
	logic [BA_W-1:0] array_bank_out;
	logic [COL_W-1:0] array_col_out;
	int error_cnt = 0;
	int total_checks = 0;

	mem_ctrl_model ctl_u (.ref_clk_in(ref_clk), .cke_out(cke), .cs_n_out(cs_n),
		.ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba), .addr_out(addr));

	ddr3_mode_ctrl dut_u (.ref_clk_in(ref_clk), .rst_in(rst), .cke_in(cke), .cs_n_in(cs_n),
		.ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(ba), .addr_in(addr),
		.lane_copy_in(lane_copy), .array_rdata_in(array_rdata), .dq_out(dq_out),
		.dq_oe_out(dq_oe_out), .beat_pos_out(beat_pos_out), .array_rd_out(array_rd_out),
		.array_wr_out(array_wr_out), .auto_precharge_out(auto_precharge_out),
		.array_bank_out(array_bank_out), .array_col_out(array_col_out),
		.mpr_mode_out(mpr_mode_out), .self_refresh_out(self_refresh_out),
		.dll_off_out(dll_off_out), .latency_error_out(latency_error_out),
		.illegal_cmd_out(illegal_cmd_out));

	// 50 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Array data moves each cycle so a stuck sample would show
	always @(posedge ref_clk) begin
		array_rdata <= array_rdata + 16'h1357;
	end

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Verdict and stop
	task automatic end_of_test();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Mode flags: readout, self refresh, DLL off, latency error
	task automatic st(input logic [3:0] e);
		#1;
		check(16'({mpr_mode_out, self_refresh_out, dll_off_out, latency_error_out}), 16'(e));
	endtask

	// Expected data word for one register bit, both byte lanes alike
	function automatic logic [15:0] exp_dq(input logic b);
		logic [7:0] lane;
		lane = lane_copy ? {8{b}} : {7'h00, b};
		return {lane, lane};
	endfunction

	// One read: request pulse, then every beat position and data against the latency
	task automatic rd_check(input logic [2:0] bk, input logic [15:0] a, input logic calibration_readout_register,
		input int beats, input logic [2:0] first, input logic [7:0] pat, input int rl);
		logic [2:0] pos;
		ctl_u.send(1'b0, 3'h5, bk, a);
		// Pass 0 looks just after the command edge, while the request pulses stand
		for (int e = 0; e <= rl + 8; e++) begin
			if (e > 0) begin
				@(posedge ref_clk);
			end
			#1;
			if (e == 0) begin
				check(16'(array_rd_out), 16'(!calibration_readout_register));
				check(16'(auto_precharge_out), 16'(!calibration_readout_register && a[COL_AP_BIT]));
				if (!calibration_readout_register) check(16'({array_bank_out, array_col_out}), 16'({bk, a[9:0]}));
			end
			if (e >= rl && e < rl + beats) begin
				pos = first + 3'(e - rl);
				check(16'({dq_oe_out, beat_pos_out}), 16'({1'b1, pos}));
				if (calibration_readout_register) begin
					check(dq_out, exp_dq(pat[pos]));
				end else begin
					check(dq_out, array_rdata - 16'h1357);
				end
			end else if (e == rl - 1 || e == rl + beats) begin
				check(16'(dq_oe_out), 16'h0000);
			end
		end
	endtask

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		error_cnt++;
		end_of_test();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		lane_copy = 1'b1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		st(4'b0000);
		// Read with auto precharge from the array, full burst at latency six
		rd_check(3'h5, 16'h0408, 1'b0, 8, 3'h0, 8'h00, 6);
		// No-operation and deselect carrying a readout enable must change nothing
		for (int i = 0; i < 2; i++) begin
			ctl_u.send(i[0], i[0] ? 3'h0 : 3'h7, MR3_SEL, 16'h0004);
			repeat (3) @(posedge ref_clk);
			st(4'b0000);
		end
		// Plain write goes to the array with its bank and column
		ctl_u.send(1'b0, 3'h4, 3'h6, 16'h0123);
		#1;
		check(16'({array_wr_out, array_bank_out, array_col_out}), 16'({1'b1, 3'h6, 10'h123}));
		// Chop chosen per command, then readout mode on
		ctl_u.mrs(MR0_SEL, 16'h0021);
		rd_check(3'h2, 16'h0000, 1'b0, 4, 3'h0, 8'h00, 6);
		ctl_u.idle_all();
		ctl_u.mrs(MR3_SEL, 16'h0004);
		st(4'b1000);
		// Don't-care address bits 3 to 11 set, auto precharge ignored, full burst
		rd_check(3'h7, 16'h1FF8, 1'b1, 8, 3'h0, 8'hAA, 6);
		@(posedge ref_clk) lane_copy <= 1'b0;
		rd_check(3'h3, 16'h0000, 1'b1, 4, 3'h0, 8'hAA, 6);
		rd_check(3'h0, 16'h0004, 1'b1, 4, 3'h4, 8'hAA, 6);
		// A write is refused while in readout mode and never reaches the array
		ctl_u.send(1'b0, 3'h4, 3'h1, 16'h0010);
		#1;
		check(16'({illegal_cmd_out, array_wr_out}), 16'h0002);
		st(4'b1000);
		// Reserved location reads back zero
		ctl_u.mrs(MR3_SEL, 16'h0005);
		rd_check(3'h0, 16'h1000, 1'b1, 8, 3'h0, 8'h00, 6);
		// Readout off with stale location bits: array again
		ctl_u.mrs(MR3_SEL, 16'h0003);
		st(4'b0000);
		rd_check(3'h1, 16'h1010, 1'b0, 8, 3'h0, 8'h00, 6);
		// DLL off through self refresh, then the early launch
		ctl_u.dll_off_enter();
		st(4'b0110);
		ctl_u.sr_exit();
		st(4'b0010);
		rd_check(3'h4, 16'h1000, 1'b0, 8, 3'h0, 8'h00, 5);
		ctl_u.mrs(MR0_SEL, 16'h0031);
		st(4'b0011);
		// DLL back on with read latency seven
		ctl_u.mrs(MR1_SEL, 16'h0000);
		st(4'b0000);
		rd_check(3'h6, 16'h1000, 1'b0, 8, 3'h0, 8'h00, 7);
		end_of_test();
	end
endmodule
